// ===== logic/drum_wc_pkg.sv
// constants, carrier types and behaviour notes for the digit and word counters
// Notes on behaviour
// - digit counter: four flip-flops, twelve states
// - digit codes follow the fixed twelve-step table
// - normal digit step at t15 while control set
// - step control set by sentinel, cleared by write complete or error hold
// - first synchronizer: address-full clears, step-set sets
// - buffer-clear digit step from gated address full
// - one-hot decode line per digit state
// - decoded state n drives read line n+1
// - connection complete clears digit counter to zero
// - buffer clear cycles digits, flushing both buffers
// - address-register-full forces digit counter to zero
// - wrap from eleven to zero issues word step
// - seven word stages plus odd-parity check bit
// - word counter advances once per completed word
// - primary step drives lowest pair, carries at 10
// - third-level step drives stages five, six, seven
// - check bit updated on every primary step
// - buffer-clear word step at digit eleven, t1357
// - normal word step at t26 after digit wrap
// - address full clears word; timer forces one
// - delayed write start steps; write control blocks force
// - decodes for word counts 98 to 101
// - equal low stages give even, unequal odd
// - even/odd indications go out to dispatcher
// - digit step every t15 while control set
// - count 101: sentinel at state 3, done at 4
package drum_wc_pkg;

  // register byte offsets on the avalon slave
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] DECODE_OFS = 4'h8;
  localparam int CTRL_GATE_BIT = 0;

  // digit codes, index is the decimal count
  localparam logic [11:0][3:0] DIGIT_CODE = {
    4'h8, 4'h9, 4'hb, 4'hf, 4'he, 4'hc,
    4'h4, 4'h6, 4'h7, 4'h3, 4'h1, 4'h0};
  localparam int DIGIT_LAST = 11;
  localparam logic [3:0] DIGIT_RESET = 4'h0;
  localparam logic [3:0] DIGIT_SENT = 4'h7;
  localparam logic [3:0] DIGIT_DONE = 4'h6;

  // word counter codes, without check bit
  localparam logic [6:0] WORD_RESET = 7'h00;
  localparam logic WORD_CHK_RESET = 1'b1;
  localparam logic [6:0] WORD_ONE = 7'h01;
  localparam logic [6:0] WORD_98 = 7'h73;
  localparam logic [6:0] WORD_99 = 7'h72;
  localparam logic [6:0] WORD_100 = 7'h74;
  localparam logic [6:0] WORD_101 = 7'h75;
  localparam logic [1:0] PAIR_CARRY = 2'b10;
  localparam int SYNC_STAGES = 2;

  // pulse inputs, all edge detected after synchronising
  typedef struct packed {
    logic t15;
    logic t26;
    logic t1357;
    logic connect_complete;
    logic addr_reg_full;
    logic sentinel_done_pulse;
    logic addr_write_step_set;
    logic start_seq_timer_out;
    logic delayed_write_start;
    logic addr_write_word_step;
  } pulse_in_t;

  // level inputs
  typedef struct packed {
    logic gated_addr_full;
    logic write_control_q;
    logic sync_error_hold;
  } level_in_t;

  typedef struct packed {
    logic [3:0] digit;
    logic [6:0] word;
    logic chk;
    logic ctl;
    logic wpend;
    logic dstep;
    logic wstep;
    logic sentinel;
    logic wdone;
    logic [11:0] dec;
    logic [11:0] even_rd;
    logic [11:0] odd_rd;
    logic even_ind;
    logic odd_ind;
    logic [3:0] wdec;
    logic gate_sw;
    pulse_in_t prev;
    logic wait_q;
    logic [31:0] rdata;
  } state_t;

endpackage

// ===== logic/two_flop_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module two_flop_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // first stage feeds only the second stage
  always_comb begin
    next_s.meta = din;
    next_s.stable = s.meta;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.stable;

endmodule

// ===== logic/drum_write_digit_word_counters.sv
// digit and word counters of the drum-write synchronizer
`timescale 1ns/1ps
module drum_write_digit_word_counters #(
  parameter bit FIRST_SYNC = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic t15,
  input wire logic t26,
  input wire logic t1357,
  input wire logic connect_complete,
  input wire logic addr_reg_full,
  input wire logic sentinel_done_pulse,
  input wire logic addr_write_step_set,
  input wire logic start_seq_timer_out,
  input wire logic delayed_write_start,
  input wire logic addr_write_word_step,
  input wire logic gated_addr_full,
  input wire logic write_control_q,
  input wire logic sync_error_hold,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [11:0] digit_state_decodes,
  output logic [11:0] even_buf_read_lines,
  output logic [11:0] odd_buf_read_lines,
  output logic digit_step_pulse,
  output logic word_step_primary,
  output logic counter_step_ctl_q,
  output logic even_count_ind,
  output logic odd_count_ind,
  output logic word_count_98_dec,
  output logic word_count_99_dec,
  output logic word_count_100_dec,
  output logic word_count_101_dec,
  output logic end_sector_sentinel_pulse,
  output logic write_complete_pulse
);

  drum_wc_pkg::pulse_in_t pin_raw;
  drum_wc_pkg::pulse_in_t pin_q;
  drum_wc_pkg::pulse_in_t ev;
  drum_wc_pkg::level_in_t lvl_raw;
  drum_wc_pkg::level_in_t lvl;
  drum_wc_pkg::state_t s;
  drum_wc_pkg::state_t next_s;

  assign pin_raw = '{t15: t15, t26: t26, t1357: t1357,
    connect_complete: connect_complete, addr_reg_full: addr_reg_full,
    sentinel_done_pulse: sentinel_done_pulse,
    addr_write_step_set: addr_write_step_set,
    start_seq_timer_out: start_seq_timer_out,
    delayed_write_start: delayed_write_start,
    addr_write_word_step: addr_write_word_step};
  assign lvl_raw = '{gated_addr_full: gated_addr_full,
    write_control_q: write_control_q, sync_error_hold: sync_error_hold};

  // pins come from other clock domains
  two_flop_sync #(.WIDTH($bits(drum_wc_pkg::pulse_in_t))) u_sync_pulse (
    .mclk(mclk),
    .rst(rst),
    .din(pin_raw),
    .dout(pin_q)
  );

  two_flop_sync #(.WIDTH($bits(drum_wc_pkg::level_in_t))) u_sync_level (
    .mclk(mclk),
    .rst(rst),
    .din(lvl_raw),
    .dout(lvl)
  );

  // a long pin pulse counts once: rising edge of the settled copy
  assign ev = pin_q & ~s.prev;

  function automatic logic [1:0] gray_next(input logic [1:0] p);
    unique case (p)
      2'b00: gray_next = 2'b01;
      2'b01: gray_next = 2'b11;
      2'b11: gray_next = 2'b10;
      2'b10: gray_next = 2'b00;
    endcase
  endfunction

  function automatic logic [3:0] digit_next(input logic [3:0] d);
    digit_next = drum_wc_pkg::DIGIT_RESET;
    for (int i = 0; i < drum_wc_pkg::DIGIT_LAST; i++) begin
      if (d == drum_wc_pkg::DIGIT_CODE[i]) begin
        digit_next = drum_wc_pkg::DIGIT_CODE[i+1];
      end
    end
  endfunction

  logic bclear;
  logic dstep;
  logic at_last;
  logic wrap;
  logic wstep;
  logic dclear;
  logic wclear;
  logic wforce;
  logic c2;
  logic c3;
  logic set7;
  logic w101;
  logic [6:0] wnext;
  logic [11:0] dec_n;
  logic acc;
  logic digit_ok;

  always_comb begin
    next_s = s;
    next_s.prev = pin_q;
    bclear = lvl.gated_addr_full;
    // digit step source depends on buffer-clear versus readout
    if (bclear) begin
      dstep = ev.t1357;
    end else begin
      dstep = s.ctl & ev.t15;
    end
    at_last = s.digit == drum_wc_pkg::DIGIT_CODE[drum_wc_pkg::DIGIT_LAST];
    digit_ok = 1'b0;
    for (int i = 0; i <= drum_wc_pkg::DIGIT_LAST; i++) begin
      digit_ok = digit_ok | (s.digit == drum_wc_pkg::DIGIT_CODE[i]);
    end
    wrap = dstep & at_last;
    dclear = ev.connect_complete | ev.addr_reg_full;

    // digit counter steps through the code table
    next_s.dstep = dstep;
    if (dclear) begin
      next_s.digit = drum_wc_pkg::DIGIT_RESET;
    end else if (dstep) begin
      next_s.digit = digit_next(s.digit);
    end

    // word step: immediate in buffer clear, at next t26 otherwise
    next_s.wpend = s.wpend;
    wstep = 1'b0;
    if (bclear) begin
      wstep = wrap;
      next_s.wpend = 1'b0;
    end else begin
      if (s.wpend && ev.t26) begin
        wstep = 1'b1;
        next_s.wpend = 1'b0;
      end
      if (wrap) begin
        next_s.wpend = 1'b1;
      end
    end
    wstep = wstep | ev.delayed_write_start | ev.addr_write_word_step;
    if (dclear) begin
      next_s.wpend = 1'b0;
    end
    next_s.wstep = wstep;

    // seven-stage counter built from three gray pairs and a top stage
    c2 = s.word[1:0] == drum_wc_pkg::PAIR_CARRY;
    c3 = c2 && s.word[3:2] == drum_wc_pkg::PAIR_CARRY;
    set7 = c3 && s.word[5:4] == drum_wc_pkg::PAIR_CARRY;
    wnext = s.word;
    wnext[1:0] = gray_next(s.word[1:0]);
    if (c2) begin
      wnext[3:2] = gray_next(s.word[3:2]);
    end
    if (c3) begin
      wnext[5:4] = gray_next(s.word[5:4]);
    end
    if (set7) begin
      wnext[6] = 1'b1;
    end
    wclear = ev.addr_reg_full;
    // write control blocks the forcing path after the first sector
    wforce = ev.start_seq_timer_out & ~lvl.write_control_q;
    if (wclear) begin
      next_s.word = drum_wc_pkg::WORD_RESET;
      next_s.chk = drum_wc_pkg::WORD_CHK_RESET;
    end else if (wforce) begin
      next_s.word = drum_wc_pkg::WORD_ONE;
      next_s.chk = 1'b0;
    end else if (wstep) begin
      next_s.word = wnext;
      // parity is recomputed, since a carry flips more than one stage
      next_s.chk = ~^wnext;
    end

    // step control flip-flop; error clear has the last word
    next_s.ctl = s.ctl;
    if (s.wdone || (FIRST_SYNC && ev.addr_reg_full)) begin
      next_s.ctl = 1'b0;
    end
    if (ev.sentinel_done_pulse) begin
      next_s.ctl = 1'b1;
    end
    if (FIRST_SYNC && ev.addr_write_step_set) begin
      next_s.ctl = 1'b1;
    end
    if (lvl.sync_error_hold) begin
      next_s.ctl = 1'b0;
    end

    // end of sector sequencing at count 101
    w101 = s.word == drum_wc_pkg::WORD_101 && !s.chk;
    next_s.sentinel = ev.t26 && w101 &&
      s.digit == drum_wc_pkg::DIGIT_SENT;
    next_s.wdone = ev.t26 && w101 &&
      s.digit == drum_wc_pkg::DIGIT_DONE;

    // registered decodes track the next state so outputs stay in step
    for (int i = 0; i <= drum_wc_pkg::DIGIT_LAST; i++) begin
      dec_n[i] = next_s.digit == drum_wc_pkg::DIGIT_CODE[i];
    end
    next_s.dec = dec_n;
    next_s.even_ind = next_s.word[1] == next_s.word[0];
    next_s.odd_ind = next_s.word[1] != next_s.word[0];
    // bit n of each bus is read line n+1
    if (bclear || s.gate_sw) begin
      next_s.even_rd = next_s.odd_ind ? dec_n : '0;
      next_s.odd_rd = next_s.even_ind ? dec_n : '0;
    end else begin
      next_s.even_rd = '0;
      next_s.odd_rd = '0;
    end
    next_s.wdec = {
      next_s.word == drum_wc_pkg::WORD_101 && !next_s.chk,
      next_s.word == drum_wc_pkg::WORD_100 && next_s.chk,
      next_s.word == drum_wc_pkg::WORD_99 && next_s.chk,
      next_s.word == drum_wc_pkg::WORD_98 && !next_s.chk};

    // avalon slave: one wait state, then the answer
    acc = (read | write) & ~s.wait_q;
    next_s.wait_q = 1'b1;
    if ((read || write) && s.wait_q) begin
      next_s.wait_q = 1'b0;
      unique case (address)
        drum_wc_pkg::CTRL_OFS: next_s.rdata = {31'h0, s.gate_sw};
        drum_wc_pkg::STATUS_OFS: next_s.rdata = {13'h0, s.wpend,
          s.dec[drum_wc_pkg::DIGIT_LAST], s.ctl, s.chk, s.word, 4'h0,
          s.digit};
        drum_wc_pkg::DECODE_OFS: next_s.rdata = {26'h0, s.odd_ind,
          s.even_ind, s.wdec};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (acc && write && address == drum_wc_pkg::CTRL_OFS &&
        byteenable[0]) begin
      next_s.gate_sw = writedata[drum_wc_pkg::CTRL_GATE_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.chk <= drum_wc_pkg::WORD_CHK_RESET;
      s.dec <= 12'h001;
      s.even_ind <= 1'b1;
      s.wait_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign readdata = s.rdata;
  assign waitrequest = s.wait_q;
  assign digit_state_decodes = s.dec;
  assign even_buf_read_lines = s.even_rd;
  assign odd_buf_read_lines = s.odd_rd;
  assign digit_step_pulse = s.dstep;
  assign word_step_primary = s.wstep;
  assign counter_step_ctl_q = s.ctl;
  assign even_count_ind = s.even_ind;
  assign odd_count_ind = s.odd_ind;
  assign word_count_98_dec = s.wdec[0];
  assign word_count_99_dec = s.wdec[1];
  assign word_count_100_dec = s.wdec[2];
  assign word_count_101_dec = s.wdec[3];
  assign end_sector_sentinel_pulse = s.sentinel;
  assign write_complete_pulse = s.wdone;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  digit_code_legal_a: assert property (
    digit_ok)
    else $error("digit counter left its code table");
  digit_wrap_a: assert property (
    (wrap && !dclear && !bclear) |=> s.digit == 4'h0 && s.wpend)
    else $error("wrap from eleven lost its word step");
  digit_clear_a: assert property (
    ev.addr_reg_full |=> s.digit == 4'h0 && s.word == 7'h00 && s.chk)
    else $error("address full did not clear both counters");
  word_parity_a: assert property (
    ^{s.chk, s.word} == 1'b1)
    else $error("word counter parity not odd");
  decode_onehot_a: assert property (
    $onehot(s.dec) && s.dec[0] == (s.digit == 4'h0))
    else $error("digit decode not one-hot or out of step");
  read_select_a: assert property (
    (s.even_rd != 12'h000 |-> s.odd_ind && s.even_rd == s.dec) and
    (s.odd_rd != 12'h000 |-> s.even_ind && s.odd_rd == s.dec))
    else $error("wrong buffer read lines enabled");
  count_ind_a: assert property (
    s.even_ind == (s.word[1] == s.word[0]) && s.odd_ind == !s.even_ind)
    else $error("odd/even indication wrong");
  ctl_error_a: assert property (
    (lvl.sync_error_hold || (s.wdone && !ev.sentinel_done_pulse &&
      !(FIRST_SYNC && ev.addr_write_step_set))) |=> !s.ctl)
    else $error("step control not cleared");
  normal_step_a: assert property (
    (!bclear && s.ctl && ev.t15) |=> s.dstep)
    else $error("missing t15 digit step");
  sector_end_a: assert property (
    s.sentinel |-> ##[1:1000] s.wdone or
    (##[1:1000] (s.ctl == 1'b0 || s.word != 7'h75)))
    else $error("no write complete after sentinel");
  word_force_a: assert property (
    (ev.start_seq_timer_out && lvl.write_control_q && !wclear && !wstep)
    |=> $stable(s.word))
    else $error("write control failed to block forcing");
  connect_clear_a: assert property (
    ev.connect_complete |=> s.digit == drum_wc_pkg::DIGIT_RESET)
    else $error("connection complete did not clear digits");
  readout_wstep_a: assert property (
    (s.wpend && ev.t26 && !bclear) |=> s.wstep)
    else $error("pending word step not taken at t26");
  clear_wstep_a: assert property (
    (bclear && wrap) |=> s.wstep)
    else $error("buffer-clear wrap gave no word step");
  force_one_a: assert property (
    (wforce && !wclear) |=> s.word == drum_wc_pkg::WORD_ONE && !s.chk)
    else $error("start timer did not force count one");

  wrap_c: cover property (wrap ##[1:20] s.wstep);
  clear_step_c: cover property (bclear && wrap);
  end_sector_c: cover property (s.sentinel ##[1:1000] s.wdone);
  count101_c: cover property (s.wdec[3]);
  force_c: cover property (wforce);

endmodule

// ===== tb/phase_source.sv
// phase pulse source standing in for the processor timing chain
`timescale 1ns/1ps
module phase_source (
  input wire logic mclk,
  input wire logic run,
  output logic t15,
  output logic t26,
  output logic t1357
);
  logic [4:0] tick = 5'h00;
  // eight phases of four clocks; halts only at a cycle boundary so
  // no phase is ever cut short
  always @(posedge mclk) begin
    if (run || tick != 5'h00) begin
      tick <= tick + 5'h01;
    end
  end
  assign t15 = tick[3:2] == 2'h1;
  assign t26 = tick[3:2] == 2'h2;
  assign t1357 = tick[2];
endmodule

// ===== tb/drum_write_digit_word_counters_tb.sv
// self-checking bench for the digit and word counters
`timescale 1ns/1ps
module drum_write_digit_word_counters_tb;
  logic mclk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, go = 1'b0;
  logic gated_addr_full = 1'b0, write_control_q = 1'b0;
  logic sync_error_hold = 1'b0, t15, t26, t1357;
  logic [6:0] pin = 7'h00;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h00000000, readdata, q;
  logic [31:0] seed = 32'hedc91900;
  logic waitrequest, digit_step_pulse, word_step_primary;
  logic counter_step_ctl_q, even_count_ind, odd_count_ind;
  logic word_count_98_dec, word_count_99_dec, word_count_100_dec;
  logic word_count_101_dec, end_sector_sentinel_pulse;
  logic write_complete_pulse;
  logic [11:0] digit_state_decodes, even_buf_read_lines;
  logic [11:0] odd_buf_read_lines;
  int mismatches = 0, n_checks = 0, dg = 0, wc = 0, n = 0;
  int nd = 0, nw = 0, ns = 0, nc = 0;
  logic [3:0] dtab [12] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'h6, 4'h4,
    4'hc, 4'he, 4'hf, 4'hb, 4'h9, 4'h8};

  phase_source ps (.mclk, .run(go), .t15, .t26, .t1357);

  drum_write_digit_word_counters dut (.mclk, .rst, .t15, .t26, .t1357,
    .connect_complete(pin[0]), .addr_reg_full(pin[1]),
    .sentinel_done_pulse(pin[2]), .addr_write_step_set(pin[3]),
    .start_seq_timer_out(pin[4]), .delayed_write_start(pin[5]),
    .addr_write_word_step(pin[6]), .gated_addr_full, .write_control_q,
    .sync_error_hold, .address, .read, .write, .writedata,
    .byteenable(4'hf), .readdata, .waitrequest, .digit_state_decodes,
    .even_buf_read_lines, .odd_buf_read_lines, .digit_step_pulse,
    .word_step_primary, .counter_step_ctl_q, .even_count_ind,
    .odd_count_ind, .word_count_98_dec, .word_count_99_dec,
    .word_count_100_dec, .word_count_101_dec, .end_sector_sentinel_pulse,
    .write_complete_pulse);

  initial begin
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (digit_step_pulse === 1'b1) nd++;
    if (word_step_primary === 1'b1) nw++;
    if (end_sector_sentinel_pulse === 1'b1) ns++;
    if (write_complete_pulse === 1'b1) nc++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [1:0] pstep(input logic [1:0] p);
    return {p[0], ~p[1]};
  endfunction

  // word code after k primary steps from zero
  function automatic logic [6:0] wcode(input int k);
    logic [6:0] w;
    logic c2, c3;
    w = 7'h00;
    repeat (k) begin
      c2 = w[1:0] == 2'b10;
      c3 = c2 && w[3:2] == 2'b10;
      if (c3 && w[5:4] == 2'b10) w[6] = 1'b1;
      if (c3) w[5:4] = pstep(w[5:4]);
      if (c2) w[3:2] = pstep(w[3:2]);
      w[1:0] = pstep(w[1:0]);
    end
    return w;
  endfunction

  task automatic cmp(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // pins are synchronised, so hold each pulse two clocks
  task automatic pulse(input int i);
    @(posedge mclk);
    pin[i] <= 1'b1;
    repeat (2) @(posedge mclk);
    pin[i] <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task automatic run(input int k);
    nd = 0;
    nw = 0;
    @(posedge mclk);
    go <= 1'b1;
    repeat ((k - 1) * 32 + 1) @(posedge mclk);
    go <= 1'b0;
    repeat (40) @(posedge mclk);
  endtask

  task automatic check_state;
    logic [31:0] s, d;
    logic [6:0] w;
    w = wcode(wc);
    bus(1'b0, 4'h4, 32'h0, s);
    bus(1'b0, 4'h8, 32'h0, d);
    cmp("digit", dtab[dg], s[3:0]);
    cmp("decodes", 32'h1 << dg, digit_state_decodes);
    cmp("word", w, s[14:8]);
    cmp("check", ~^w, s[15]);
    cmp("even", w[1] == w[0], even_count_ind);
    cmp("odd", w[1] != w[0], odd_count_ind);
    cmp("dec", {wc == 101, wc == 100, wc == 99, wc == 98},
      {word_count_101_dec, word_count_100_dec, word_count_99_dec,
      word_count_98_dec});
    cmp("decreg", {wc == 101, wc == 100, wc == 99, wc == 98},
      d[3:0]);
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    cmp("waitreq", 1'b1, waitrequest);
    check_state();
    for (int i = 1; i <= 101; i++) begin
      pulse(6);
      wc = i;
      check_state();
    end
    pulse(0);
    pulse(2);
    cmp("ctl set", 1'b1, counter_step_ctl_q);
    ns = 0;
    nc = 0;
    run(2);
    dg = 4;
    cmp("sentinel", 1, ns);
    cmp("complete", 1, nc);
    cmp("ctl end", 1'b0, counter_step_ctl_q);
    check_state();
    pulse(3);
    cmp("ctl aset", 1'b1, counter_step_ctl_q);
    pulse(1);
    cmp("ctl afull", 1'b0, counter_step_ctl_q);
    dg = 0;
    wc = 0;
    check_state();
    pulse(4);
    wc = 1;
    check_state();
    pulse(2);
    seed = lfsr(seed);
    n = 1 + seed[4:0];
    run(n);
    cmp("t15 steps", 2 * n, nd);
    cmp("wraps", (dg + 2 * n) / 12, nw);
    wc = wc + (dg + 2 * n) / 12;
    dg = (dg + 2 * n) % 12;
    check_state();
    @(posedge mclk);
    sync_error_hold <= 1'b1;
    repeat (8) @(posedge mclk);
    cmp("ctl err", 1'b0, counter_step_ctl_q);
    sync_error_hold <= 1'b0;
    gated_addr_full <= 1'b1;
    seed = lfsr(seed);
    n = 6 + seed[2:0];
    run(n);
    cmp("clr steps", 4 * n, nd);
    cmp("clr wraps", (dg + 4 * n) / 12, nw);
    wc = wc + (dg + 4 * n) / 12;
    dg = (dg + 4 * n) % 12;
    check_state();
    q = {20'h0, 12'h1 << dg};
    cmp("even lines", wcode(wc) % 2 != wcode(wc) / 2 % 2 ? q : 0,
      even_buf_read_lines);
    cmp("odd lines", wcode(wc) % 2 == wcode(wc) / 2 % 2 ? q : 0,
      odd_buf_read_lines);
    gated_addr_full <= 1'b0;
    repeat (8) @(posedge mclk);
    cmp("lines off", 0, even_buf_read_lines | odd_buf_read_lines);
    seed = lfsr(seed);
    bus(1'b1, 4'h0, {seed[31:1], 1'b1}, q);
    bus(1'b0, 4'h0, 32'h0, q);
    cmp("ctrl rb", 1'b1, q[0]);
    repeat (4) @(posedge mclk);
    cmp("lines sw", {20'h0, 12'h1 << dg},
      even_buf_read_lines | odd_buf_read_lines);
    bus(1'b0, 4'hc, 32'h0, q);
    cmp("unmapped", 0, q);
    pulse(0);
    dg = 0;
    check_state();
    write_control_q <= 1'b1;
    pulse(1);
    pulse(4);
    wc = 0;
    check_state();
    pulse(5);
    wc = 1;
    check_state();
    end_sim();
  end
endmodule
